//--- include/lmcd_consts.svh
// Constants of the motion command decoder: register offsets, field positions,
// reset values, frame codes and frame lengths.
// Assumes inclusion by bare name from the design file.
`ifndef LMCD_CONSTS_SVH
`define LMCD_CONSTS_SVH

// Register word offsets on the Avalon-MM slave.
`define LMCD_OFF_NODE     4'h0
`define LMCD_OFF_IDCFG    4'h1
`define LMCD_OFF_SECURE   4'h2
`define LMCD_OFF_STATUS   4'h3
`define LMCD_OFF_POSITION 4'h4

// Field positions.
`define LMCD_IDCFG_PARAM_LSB  0
`define LMCD_IDCFG_INDIV_LSB  8
`define LMCD_IDCFG_GROUP_LSB  16
`define LMCD_SECURE_EN_BIT    16
`define LMCD_ST_SHUTDOWN_BIT  2

// Reset values.
`define LMCD_RST_NODE   8'h20
`define LMCD_RST_PARAM  6'h00
`define LMCD_RST_INDIV  6'h01
`define LMCD_RST_GROUP  6'h02

// Frame codes.
`define LMCD_NAD_BCAST   8'h7f
`define LMCD_CMD_SECURE  8'h04
`define LMCD_CMD_HALT    8'h05
`define LMCD_CMD_ZERO    8'h06
`define LMCD_CMD_DUAL    8'h08
`define LMCD_CSUM_GOOD   8'hff

// Frame lengths in bytes, identifier and checksum included.
`define LMCD_LEN_GROUP   4'h3
`define LMCD_LEN_INDIV   4'h4
`define LMCD_LEN_DUAL    4'h9
`define LMCD_LEN_OVER    4'ha

`endif

//--- include/lmcd_pkg.sv
// Types shared by the motion command decoder.
// Assumes the constants header sits beside it.
package lmcd_pkg;
    typedef logic [15:0] lmcd_pos_t;
    typedef logic [7:0]  lmcd_byte_t;

    // Phases of the two-speed positioning sequence.
    typedef enum logic [1:0]
    {
        LMCD_IDLE   = 2'b00,
        LMCD_FIRST  = 2'b01,
        LMCD_SECOND = 2'b10
    } lmcd_dual_e;
endpackage : lmcd_pkg

//--- logic/lmcd_decoder.sv
// Motion command decoder of a LIN stepper slave: takes received frame bytes,
// checks address, identifier and checksum, and runs secure move, halt,
// position zeroing and the two-speed positioning sequence.
// Assumes a data-link layer that delivers each frame as a start pulse, one
// valid pulse per byte (protected identifier first, checksum last) and an end
// pulse in a cycle without a byte; all inputs are synchronous to clock.
//
// Behaviour
// - Code 04 moves to secure position
// - Accept own node address or broadcast 7F
// - Group frame acts on nodes holding its identifier
// - Code 05 requests an immediate halt
// - Coil fault triggers halt and shutdown
// - Halt while moving sets step loss
// - After halt standstill, target takes actual
// - Bus halt command runs the same halt
// - Code 06 requests position zeroing
// - Zeroing clears actual and target positions
// - Zeroing sets reference done
// - Two-speed frame: nine bytes, code 08
// - Upper nibble is first motion top speed
// - Lower nibble is low and second speed
// - Bytes two, three: absolute first target
// - Bytes four, five: relative second displacement
// - Two-speed completion sets reference done
// - Two-speed sequence blocks other positioning
// - Secure move ignores the secure enable
// - Quick status read clears step loss
`timescale 1ns/1ps
`include "lmcd_consts.svh"

module lmcd_decoder
(
    // Clock and reset.
    input  wire logic        clock,
    input  wire logic        srst,
    // Avalon-MM register slave.
    input  wire logic [3:0]  avs_address,
    input  wire logic        avs_read,
    input  wire logic        avs_write,
    input  wire logic [31:0] avs_writedata,
    output logic      [31:0] avs_readdata,
    output logic             avs_waitrequest,
    // Received frame stream.
    input  wire logic        rx_start,
    input  wire logic        rx_valid,
    input  wire logic [7:0]  rx_byte,
    input  wire logic        rx_end,
    // Motor and status inputs.
    input  wire logic        motor_moving,
    input  wire logic        step_pulse,
    input  wire logic        step_dir,
    input  wire logic        coil_fault,
    input  wire logic        quick_status_read,
    // Position controller outputs.
    output logic      [15:0] actual_position,
    output logic      [15:0] target_position,
    output logic             motion_go,
    output logic             immediate_halt,
    output logic      [3:0]  vmax_code,
    output logic      [3:0]  vmin_code,
    output logic             speed_override,
    // Status outputs.
    output logic             step_loss_flag,
    output logic             ref_done,
    output logic             shutdown,
    output logic             dual_busy
);

    ////////////////////////////////////////////////////////////////////////
    // Adds two bytes with the end-around carry of the enhanced checksum.
    function automatic logic [7:0] csum_add(input logic [7:0] a, input logic [7:0] b);
        logic [8:0] s;
        s = {1'b0, a} + {1'b0, b};
        return s[7:0] + {7'h00, s[8]};
    endfunction : csum_add

    ////////////////////////////////////////////////////////////////////////
    // Register state.
    logic [7:0]           node_q;
    logic [5:0]           param_id_q;
    logic [5:0]           indiv_id_q;
    logic [5:0]           group_id_q;
    logic [10:0]          secure_q;
    logic                 secure_en_q;
    lmcd_pkg::lmcd_byte_t frame_q [0:8];
    logic [3:0]           cnt_q;
    logic [7:0]           sum_q;
    lmcd_pkg::lmcd_dual_e dual_q;
    lmcd_pkg::lmcd_dual_e dual_d;
    lmcd_pkg::lmcd_pos_t  act_q;
    lmcd_pkg::lmcd_pos_t  act_d;
    lmcd_pkg::lmcd_pos_t  tgt_q;
    lmcd_pkg::lmcd_pos_t  tgt_d;
    lmcd_pkg::lmcd_pos_t  offset_q;
    logic [3:0]           vmax_q;
    logic [3:0]           vmin_q;
    logic                 halt_pend_q;
    logic                 fault_prev_q;
    logic                 step_loss_q;
    logic                 ref_done_q;
    logic                 shutdown_q;
    logic                 go_q;
    logic                 halt_q;
    logic                 wait_q;
    logic                 busy_q;
    logic [31:0]          rdata_q;

    ////////////////////////////////////////////////////////////////////////
    // Frame decode.
    wire [5:0] frame_id    = frame_q[0][5:0];
    wire       nad_ok      = (frame_q[1] == node_q) || (frame_q[1] == `LMCD_NAD_BCAST);
    wire       csum_ok     = (sum_q == `LMCD_CSUM_GOOD);
    wire       indiv_frame = (frame_id == indiv_id_q) && (cnt_q == `LMCD_LEN_INDIV) && nad_ok;
    wire       group_frame = (frame_id == group_id_q) && (cnt_q == `LMCD_LEN_GROUP);
    wire [7:0] addr_cmd    = indiv_frame ? frame_q[2] : frame_q[1];
    wire       addr_ok     = rx_end && csum_ok && (indiv_frame || group_frame);
    wire       busy        = (dual_q != lmcd_pkg::LMCD_IDLE);
    wire       wr_fire     = avs_write && !wait_q;
    wire       go_secure   = addr_ok && (addr_cmd == `LMCD_CMD_SECURE) && !busy;
    wire       halt_bus    = addr_ok && (addr_cmd == `LMCD_CMD_HALT);
    wire       zero_cmd    = addr_ok && (addr_cmd == `LMCD_CMD_ZERO) && !busy;
    wire       dual_cmd    = rx_end && csum_ok && (frame_id == param_id_q) && nad_ok
                             && (cnt_q == `LMCD_LEN_DUAL) && (frame_q[2] == `LMCD_CMD_DUAL) && !busy;

    // Halt sources: the bus command and the rising edge of a coil fault.
    wire       fault_rise  = coil_fault && !fault_prev_q;
    wire       halt_trig   = halt_bus || fault_rise;
    wire       halt_done   = halt_pend_q && !motor_moving;

    // The sequence phase ends once the motor stands still on its target.
    wire       reached     = !motor_moving && (act_q == tgt_q) && !go_q;
    wire       dual_finish = (dual_q == lmcd_pkg::LMCD_SECOND) && reached && !halt_trig;

    ////////////////////////////////////////////////////////////////////////
    // Frame capture and running checksum.
    always_ff @(posedge clock)
    begin
        if (srst || rx_start)
        begin
            cnt_q <= 4'h0;
            sum_q <= 8'h00;
        end
        else if (rx_valid)
        begin
            if (cnt_q < `LMCD_LEN_DUAL)
                frame_q[cnt_q] <= rx_byte;
            cnt_q <= (cnt_q == `LMCD_LEN_OVER) ? cnt_q : cnt_q + 4'h1;
            sum_q <= csum_add(sum_q, rx_byte);
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Two-speed sequence phase selection; a halt aborts it.
    always_comb
    begin
        dual_d = dual_q;
        unique case (dual_q)
            lmcd_pkg::LMCD_IDLE:   if (dual_cmd) dual_d = lmcd_pkg::LMCD_FIRST;
            lmcd_pkg::LMCD_FIRST:  if (halt_trig) dual_d = lmcd_pkg::LMCD_IDLE;
                                   else if (reached) dual_d = lmcd_pkg::LMCD_SECOND;
            lmcd_pkg::LMCD_SECOND: if (halt_trig || reached) dual_d = lmcd_pkg::LMCD_IDLE;
            default:               dual_d = lmcd_pkg::LMCD_IDLE;
        endcase
    end

    // Position next values: zeroing first, then halt hold, then new targets.
    wire second_load = (dual_q == lmcd_pkg::LMCD_FIRST) && reached && !halt_trig;
    assign act_d = zero_cmd   ? 16'h0000
                 : step_pulse ? (step_dir ? act_q - 16'h0001 : act_q + 16'h0001)
                 : act_q;
    assign tgt_d = zero_cmd    ? 16'h0000
                 : halt_done   ? act_q
                 : dual_cmd    ? {frame_q[5], frame_q[4]}
                 : second_load ? act_q + offset_q
                 : go_secure   ? {5'h00, secure_q}
                 : tgt_q;

    ////////////////////////////////////////////////////////////////////////
    // Motion state.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            dual_q       <= lmcd_pkg::LMCD_IDLE;
            act_q        <= 16'h0000;
            tgt_q        <= 16'h0000;
            offset_q     <= 16'h0000;
            vmax_q       <= 4'h0;
            vmin_q       <= 4'h0;
            go_q         <= 1'b0;
            halt_q       <= 1'b0;
            halt_pend_q  <= 1'b0;
            fault_prev_q <= 1'b0;
            busy_q       <= 1'b0;
        end
        else
        begin
            dual_q       <= dual_d;
            busy_q       <= (dual_d != lmcd_pkg::LMCD_IDLE);
            act_q        <= act_d;
            tgt_q        <= tgt_d;
            fault_prev_q <= coil_fault;
            go_q         <= go_secure || dual_cmd || second_load;
            halt_q       <= halt_trig;
            halt_pend_q  <= halt_trig || (halt_pend_q && motor_moving);
            if (dual_cmd)
            begin
                vmax_q   <= frame_q[3 + 0][7:4];
                vmin_q   <= frame_q[3][3:0];
                offset_q <= {frame_q[7], frame_q[6]};
            end
            else if (second_load)
                vmax_q <= vmin_q;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Sticky flags; a setting event wins over a clear in the same cycle.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            step_loss_q <= 1'b0;
            ref_done_q  <= 1'b0;
            shutdown_q  <= 1'b0;
        end
        else
        begin
            step_loss_q <= (halt_trig && motor_moving)
                           || (step_loss_q && !quick_status_read);
            ref_done_q  <= zero_cmd || dual_finish || ref_done_q;
            shutdown_q  <= fault_rise || (shutdown_q && !(wr_fire && avs_address == `LMCD_OFF_STATUS
                           && avs_writedata[`LMCD_ST_SHUTDOWN_BIT]));
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Avalon-MM slave: one wait cycle, then the access completes.
    wire [31:0] idcfg    = {10'h000, group_id_q, 2'b00, indiv_id_q, 2'b00, param_id_q};
    wire [31:0] status   = {27'h0, dual_q == lmcd_pkg::LMCD_SECOND, busy, shutdown_q,
                            ref_done_q, step_loss_q};
    wire [31:0] rd_mux   = (avs_address == `LMCD_OFF_NODE)     ? {24'h000000, node_q}
                         : (avs_address == `LMCD_OFF_IDCFG)    ? idcfg
                         : (avs_address == `LMCD_OFF_SECURE)   ? {15'h0000, secure_en_q, 5'h00, secure_q}
                         : (avs_address == `LMCD_OFF_STATUS)   ? status
                         : (avs_address == `LMCD_OFF_POSITION) ? {tgt_q, act_q}
                         : 32'h00000000;

    // Bus handshake and read data.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h00000000;
        end
        else
        begin
            wait_q  <= !((avs_read || avs_write) && wait_q);
            rdata_q <= rd_mux;
        end
    end

    // Configuration registers written by software.
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            node_q      <= `LMCD_RST_NODE;
            param_id_q  <= `LMCD_RST_PARAM;
            indiv_id_q  <= `LMCD_RST_INDIV;
            group_id_q  <= `LMCD_RST_GROUP;
            secure_q    <= 11'h000;
            secure_en_q <= 1'b0;
        end
        else if (wr_fire)
        begin
            if (avs_address == `LMCD_OFF_NODE)
                node_q <= avs_writedata[7:0];
            if (avs_address == `LMCD_OFF_IDCFG)
            begin
                param_id_q <= avs_writedata[`LMCD_IDCFG_PARAM_LSB +: 6];
                indiv_id_q <= avs_writedata[`LMCD_IDCFG_INDIV_LSB +: 6];
                group_id_q <= avs_writedata[`LMCD_IDCFG_GROUP_LSB +: 6];
            end
            if (avs_address == `LMCD_OFF_SECURE)
            begin
                secure_q    <= avs_writedata[10:0];
                secure_en_q <= avs_writedata[`LMCD_SECURE_EN_BIT];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Outputs straight from flip-flops.
    assign avs_readdata    = rdata_q;
    assign avs_waitrequest = wait_q;
    assign actual_position = act_q;
    assign target_position = tgt_q;
    assign motion_go       = go_q;
    assign immediate_halt  = halt_q;
    assign vmax_code       = vmax_q;
    assign vmin_code       = vmin_q;
    assign speed_override  = busy_q;
    assign step_loss_flag  = step_loss_q;
    assign ref_done        = ref_done_q;
    assign shutdown        = shutdown_q;
    assign dual_busy       = busy_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks on the decoder behaviour.
    property p_secure_load;
        @(posedge clock) disable iff (srst)
        go_secure && !zero_cmd && !halt_done && !dual_cmd |=> tgt_q == {5'h00, $past(secure_q)} && go_q;
    endproperty
    a_secure_load: assert property (p_secure_load)
        else $error("Secure command did not load the secure position.");

    property p_foreign_nad;
        @(posedge clock) disable iff (srst)
        rx_end && frame_id == indiv_id_q && frame_id != group_id_q && frame_id != param_id_q
        && frame_q[1] != node_q && frame_q[1] != `LMCD_NAD_BCAST
        && !fault_rise && !second_load |=> !go_q && !halt_q;
    endproperty
    a_foreign_nad: assert property (p_foreign_nad)
        else $error("Frame for another node was acted on.");

    property p_bad_csum;
        @(posedge clock) disable iff (srst)
        rx_end && !csum_ok && !fault_rise && !second_load |=> !go_q && !halt_q;
    endproperty
    a_bad_csum: assert property (p_bad_csum)
        else $error("Frame with a bad checksum was acted on.");

    property p_fault_halt;
        @(posedge clock) disable iff (srst)
        coil_fault && !fault_prev_q |=> halt_q && shutdown_q;
    endproperty
    a_fault_halt: assert property (p_fault_halt)
        else $error("Coil fault did not halt and shut down.");

    property p_step_loss;
        @(posedge clock) disable iff (srst)
        halt_trig && motor_moving |=> step_loss_q [*2] or (step_loss_q ##1 $past(quick_status_read));
    endproperty
    a_step_loss: assert property (p_step_loss)
        else $error("Halt while moving did not raise step loss.");

    property p_halt_hold;
        @(posedge clock) disable iff (srst)
        halt_pend_q && !motor_moving && !zero_cmd |=> tgt_q == $past(act_q);
    endproperty
    a_halt_hold: assert property (p_halt_hold)
        else $error("Target did not take the stop position.");

    property p_zero;
        @(posedge clock) disable iff (srst)
        zero_cmd |=> act_q == 16'h0000 && tgt_q == 16'h0000 && ref_done_q;
    endproperty
    a_zero: assert property (p_zero)
        else $error("Zeroing did not clear positions and set reference done.");

    property p_dual_done;
        @(posedge clock) disable iff (srst)
        dual_finish |=> ref_done_q && dual_q == lmcd_pkg::LMCD_IDLE;
    endproperty
    a_dual_done: assert property (p_dual_done)
        else $error("Two-speed completion did not set reference done.");

    property p_dual_guard;
        @(posedge clock) disable iff (srst)
        busy && !halt_done && !second_load |=> $stable(tgt_q) || $past(step_pulse) == 1'b0 && $stable(tgt_q);
    endproperty
    a_dual_guard: assert property (p_dual_guard)
        else $error("Positioning command replaced a running two-speed move.");

    property p_dual_speed;
        @(posedge clock) disable iff (srst)
        dual_cmd |=> vmax_q == $past(frame_q[3][7:4]) && vmin_q == $past(frame_q[3][3:0])
                     && dual_q == lmcd_pkg::LMCD_FIRST;
    endproperty
    a_dual_speed: assert property (p_dual_speed)
        else $error("Two-speed codes were not taken from the first data byte.");

endmodule : lmcd_decoder

//--- verification/lmcd_lin_master.sv
// LIN master stand-in: sends command frames to the decoder as a byte stream.
// Assumes the decoder samples the rx lines on the rising edge of clock.
`timescale 1ns/1ps
module lmcd_lin_master
(
    // Clock.
    input  wire logic       clock,
    // Frame stream.
    output logic            rx_start,
    output logic            rx_valid,
    output logic      [7:0] rx_byte,
    output logic            rx_end
);
    ////////////////////////////////////////
    // Lines start quiet; the idle byte lane is inverted so no stale byte looks fresh.
    initial
    begin
        rx_start = 1'b0;
        rx_valid = 1'b0;
        rx_byte  = 8'h5a;
        rx_end   = 1'b0;
    end

    // Presents one byte, then idles for gap cycles with the lane inverted.
    task automatic put(input logic [7:0] b, input int gap);
        rx_valid <= 1'b1;
        rx_byte  <= b;
        @(posedge clock);
        if (gap > 0)
        begin
            rx_valid <= 1'b0;
            rx_byte  <= ~b;
            repeat (gap) @(posedge clock);
        end
    endtask : put

    // Sends identifier, n body bytes low first, then the enhanced checksum.
    task automatic send(input logic [7:0] id, input logic [63:0] body, input int n, input logic bad,
                        input int gap);
        logic [7:0] acc;
        logic [8:0] t;
        acc = id;
        for (int i = 0; i < n; i++)
        begin
            t   = {1'b0, acc} + {1'b0, body[8*i+:8]};
            acc = t[7:0] + {7'h0, t[8]};
        end
        @(posedge clock);
        rx_start <= 1'b1;
        @(posedge clock);
        rx_start <= 1'b0;
        put(id, gap);
        for (int i = 0; i < n; i++)
        begin
            put(body[8*i+:8], gap);
        end
        put(~acc ^ {7'h0, bad}, gap);
        rx_valid <= 1'b0;
        rx_byte  <= ~rx_byte;
        rx_end   <= 1'b1;
        @(posedge clock);
        rx_end   <= 1'b0;
    endtask : send
endmodule : lmcd_lin_master

//--- verification/tb_lin_motion_command_decoder.sv
// Self-checking bench of the motion command decoder, fed by the master model.
// Assumes the decoder, its package, header and the master model are compiled first.
`timescale 1ns/1ps
module tb_lin_motion_command_decoder;
    // Bench-driven inputs.
    logic        clock = 1'b0, srst = 1'b1, avs_read = 1'b0, avs_write = 1'b0;
    logic [3:0]  avs_address = 4'h0;
    logic [31:0] avs_writedata = 32'h0, avs_readdata, rd;
    logic        motor_moving = 1'b0, step_pulse = 1'b0, step_dir = 1'b0;
    logic        coil_fault = 1'b0, quick_status_read = 1'b0;
    // Decoder outputs and frame lines.
    logic        avs_waitrequest, rx_start, rx_valid, rx_end, motion_go, immediate_halt;
    logic        speed_override, step_loss_flag, ref_done, shutdown, dual_busy;
    logic [7:0]  rx_byte;
    logic [15:0] actual_position, target_position;
    logic [3:0]  vmax_code, vmin_code;
    int          miscompares = 0, checked = 0;

    ////////////////////////////////////////
    // Design and frame source.
    lmcd_decoder lmcd_decoder_inst
    (
        .clock(clock), .srst(srst), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .rx_start(rx_start), .rx_valid(rx_valid),
        .rx_byte(rx_byte), .rx_end(rx_end), .motor_moving(motor_moving), .step_pulse(step_pulse),
        .step_dir(step_dir), .coil_fault(coil_fault), .quick_status_read(quick_status_read),
        .actual_position(actual_position), .target_position(target_position), .motion_go(motion_go),
        .immediate_halt(immediate_halt), .vmax_code(vmax_code), .vmin_code(vmin_code),
        .speed_override(speed_override), .step_loss_flag(step_loss_flag), .ref_done(ref_done),
        .shutdown(shutdown), .dual_busy(dual_busy)
    );
    lmcd_lin_master lmcd_lin_master_inst
    (
        .clock(clock), .rx_start(rx_start), .rx_valid(rx_valid), .rx_byte(rx_byte), .rx_end(rx_end)
    );

    ////////////////////////////////////////
    // Clock of 20 ns period.
    initial
    begin
        forever #10 clock = ~clock;
    end

    // Compares one value and counts the outcome.
    task automatic check(input string nm, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e)
        begin
            miscompares++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : check

    // One Avalon access; the request is held until waitrequest is sampled low.
    task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] wd);
        int k;
        k = 0;
        @(posedge clock);
        avs_read <= !wr;
        avs_write <= wr;
        avs_address <= a;
        avs_writedata <= wd;
        do
        begin
            @(posedge clock);
            k++;
        end while (avs_waitrequest !== 1'b0);
        rd = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        check("bus wait", 32'h2, k);
    endtask : bus

    // Reads a register and compares it.
    task automatic rdchk(input logic [3:0] a, input logic [31:0] e);
        bus(1'b0, a, 32'h0);
        check("register", e, rd);
    endtask : rdchk

    // Individual frame, group frame and stepping helpers.
    task automatic ind(input logic [7:0] nad, input logic [7:0] cmd, input logic bad, input int gap);
        lmcd_lin_master_inst.send(8'h01, {48'h0, cmd, nad}, 2, bad, gap);
        #1;
    endtask : ind
    task automatic grp(input logic [7:0] id, input logic [7:0] cmd);
        lmcd_lin_master_inst.send(id, {56'h0, cmd}, 1, 1'b0, 0);
        #1;
    endtask : grp
    task automatic step(input logic d, input int n);
        repeat (n)
        begin
            @(posedge clock);
            step_pulse <= 1'b1;
            step_dir <= d;
            @(posedge clock);
            step_pulse <= 1'b0;
        end
    endtask : step

    // Waits a bounded time for a level, then compares it.
    task automatic waitfor(ref logic s, input logic v, input int lim);
        int k;
        k = 0;
        while (s !== v && k < lim)
        begin
            @(posedge clock);
            k++;
        end
        check("wait", {31'h0, v}, {31'h0, s});
    endtask : waitfor

    // Holds reset for eight cycles.
    task automatic do_reset();
        @(posedge clock);
        srst <= 1'b1;
        repeat (8) @(posedge clock);
        srst <= 1'b0;
    endtask : do_reset

    // Prints counts and verdict, then stops.
    task automatic conclude();
        $display("checked %0d miscompares %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : conclude

    ////////////////////////////////////////
    // Watchdog against a hang.
    initial
    begin
        repeat (20000) @(posedge clock);
        miscompares++;
        conclude();
    end

    // Test sequence.
    initial
    begin
        do_reset();
        rdchk(4'h0, 32'h20);
        rdchk(4'h1, 32'h00020100);
        rdchk(4'h5, 32'h0);
        bus(1'b1, 4'h2, 32'h000007ff);
        ind(8'h20, 8'h04, 1'b0, 0);
        check("go", 32'h1, {31'h0, motion_go});
        check("target", 32'h7ff, 32'(target_position));
        bus(1'b1, 4'h2, 32'h00000123);
        ind(8'h21, 8'h04, 1'b0, 0);
        ind(8'h7f, 8'h04, 1'b1, 0);
        check("target", 32'h7ff, 32'(target_position));
        ind(8'h7f, 8'h04, 1'b0, 2);
        check("target", 32'h123, 32'(target_position));
        bus(1'b1, 4'h1, 32'h00050100);
        bus(1'b1, 4'h2, 32'h00000456);
        grp(8'h02, 8'h04);
        check("target", 32'h123, 32'(target_position));
        grp(8'h05, 8'h04);
        check("target", 32'h456, 32'(target_position));
        $display("test secure done");
        @(posedge clock);
        motor_moving <= 1'b1;
        step(1'b0, 3);
        grp(8'h05, 8'h05);
        check("halt", 32'h1, {31'h0, immediate_halt});
        check("step loss", 32'h1, {31'h0, step_loss_flag});
        @(posedge clock);
        motor_moving <= 1'b0;
        repeat (3) @(posedge clock);
        #1;
        check("target", 32'h3, 32'(target_position));
        @(posedge clock);
        quick_status_read <= 1'b1;
        @(posedge clock);
        quick_status_read <= 1'b0;
        ind(8'h20, 8'h05, 1'b0, 0);
        check("step loss", 32'h0, {31'h0, step_loss_flag});
        $display("test halt done");
        ind(8'h20, 8'h06, 1'b0, 0);
        check("actual", 32'h0, 32'(actual_position));
        check("ref done", 32'h1, {31'h0, ref_done});
        bus(1'b1, 4'h4, 32'hffffffff);
        rdchk(4'h4, 32'h0);
        @(posedge clock);
        coil_fault <= 1'b1;
        waitfor(immediate_halt, 1'b1, 8);
        rdchk(4'h3, 32'h6);
        coil_fault <= 1'b0;
        bus(1'b1, 4'h3, 32'h4);
        rdchk(4'h3, 32'h2);
        $display("test zero and fault done");
        do_reset();
        bus(1'b1, 4'h2, 32'h00000100);
        lmcd_lin_master_inst.send(8'h00, {8'h0, 16'hfffe, 16'h0005, 8'ha3, 8'h08, 8'h20}, 7, 1'b0, 0);
        #1;
        check("vmax", 32'ha, 32'(vmax_code));
        check("vmin", 32'h3, 32'(vmin_code));
        check("target", 32'h5, 32'(target_position));
        check("override", 32'h1, {31'h0, speed_override});
        ind(8'h20, 8'h04, 1'b0, 0);
        check("target", 32'h5, 32'(target_position));
        @(posedge clock);
        motor_moving <= 1'b1;
        step(1'b0, 5);
        motor_moving <= 1'b0;
        waitfor(motion_go, 1'b1, 40);
        check("target", 32'h3, 32'(target_position));
        check("vmax", 32'h3, 32'(vmax_code));
        check("ref done", 32'h0, {31'h0, ref_done});
        @(posedge clock);
        motor_moving <= 1'b1;
        step(1'b1, 2);
        motor_moving <= 1'b0;
        waitfor(dual_busy, 1'b0, 40);
        #1;
        check("ref done", 32'h1, {31'h0, ref_done});
        $display("test two speed done");
        conclude();
    end
endmodule : tb_lin_motion_command_decoder
